// File: etc_pkg.sv
// Notes on behaviour
// [R1] edge select one means rising, zero falling
// [R2] valid selected edge sets that input's flag
// [R3] cleared enable blocks request; flag still sets
// [R4] software clears flag before re-enabling source
// [R5] enabled-before-sleep external interrupt wakes the core
// [R6] after wake, vector only under global enable
// [R7] sources one to three have priority bits
// [R8] external source zero is always high priority
// [R9] 8-bit timer wrap sets overflow flag
// [R10] 16-bit timer wrap sets overflow flag
// [R11] timer overflow enable at main bit 5
// [R12] timer priority at second register bit 2
// [R13] change on upper port pins sets flag
// [R14] port-change enable at main bit 3
// [R15] port-change priority at second register bit 0
// [R16] accepted interrupt pushes return address
// [R17] accepted interrupt copies three core registers
// [R18] software saves registers without fast return
// [R19] priority-enable bit turns on two levels
// [R20] flags stay set until software clears
package etc_pkg;
  localparam logic [4:0]  OFS_MAIN      = 5'h00;
  localparam logic [4:0]  OFS_SECOND    = 5'h04;
  localparam logic [4:0]  OFS_THIRD     = 5'h08;
  localparam logic [4:0]  OFS_RSTC      = 5'h0c;
  localparam logic [4:0]  OFS_TMR_CFG   = 5'h10;
  localparam logic [4:0]  OFS_TMR_CNT   = 5'h14;
  localparam logic [4:0]  OFS_PORT      = 5'h18;
  localparam logic [4:0]  OFS_STATUS    = 5'h1c;
  // main control fields
  localparam int          MAIN_GLB      = 7;
  localparam int          MAIN_GIEL     = 6;
  localparam int          MAIN_TMR_EN   = 5;
  localparam int          MAIN_EXT0_EN  = 4;
  localparam int          MAIN_PC_EN    = 3;
  localparam int          MAIN_TMR_FLAG = 2;
  localparam int          MAIN_EXT0_FLAG = 1;
  localparam int          MAIN_PC_FLAG  = 0;
  // second control fields
  localparam int          SEC_EDGE_LSB  = 3;
  localparam int          SEC_TMR_PRIO  = 2;
  localparam int          SEC_EXT3_PRIO = 1;
  localparam int          SEC_PC_PRIO   = 0;
  // third control, reset control, timer config and port fields
  localparam int          THD_EXT2_PRIO = 7;
  localparam int          THD_EXT1_PRIO = 6;
  localparam int          THD_EN_LSB    = 3;
  localparam int          THD_FLAG_LSB  = 0;
  localparam int          RSTC_PLEN     = 7;
  localparam int          CFG_RUN       = 0;
  localparam int          CFG_MODE16    = 1;
  localparam int          PORT_LSB      = 4;
  // values after reset and the two vector addresses
  localparam logic [7:0]  MAIN_RST      = 8'h00;
  localparam logic [7:0]  SEC_RST       = 8'h7f;
  localparam logic [7:0]  THD_RST       = 8'hc0;
  localparam logic [7:0]  RSTC_RST      = 8'h00;
  localparam logic [7:0]  CFG_RST       = 8'h00;
  localparam logic [15:0] VEC_HIGH      = 16'h0008;
  localparam logic [15:0] VEC_LOW       = 16'h0018;
endpackage

// File: etc_edge_detect.sv
`timescale 1ns/1ns
module etc_edge_detect
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic pin,
  input  wire logic rising_sel,
  output logic      edge_pulse_ff
);

  logic prev_ff;
  logic primed_ff;

  // first sample after reset only primes, so a pin held high is no edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev_ff   <= 1'b0;
      primed_ff <= 1'b0;
    end
    else if (ce)
    begin
      prev_ff   <= pin;
      primed_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      edge_pulse_ff <= 1'b0;
    else if (ce)
      edge_pulse_ff <= primed_ff & (rising_sel ? (pin & ~prev_ff) : (~pin & prev_ff)); // R1
  end

endmodule

// File: etc_shadow_store.sv
`timescale 1ns/1ns
module etc_shadow_store
#(
  parameter int W = 8
)
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         capture,
  input  wire logic [W-1:0] work_in,
  input  wire logic [W-1:0] status_in,
  input  wire logic [W-1:0] bnk_in,
  output logic      [W-1:0] work_ff,
  output logic      [W-1:0] status_ff,
  output logic      [W-1:0] bnk_ff
);

  // one-deep fast shadow, overwritten by each accepted interrupt
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      work_ff   <= '0;
      status_ff <= '0;
      bnk_ff    <= '0;
    end
    else if (ce && capture)
    begin
      work_ff   <= work_in;   // R17
      status_ff <= status_in;
      bnk_ff    <= bnk_in;
    end
  end

endmodule

// File: etc_irq_sources.sv
`timescale 1ns/1ns
module etc_irq_sources
#(
  parameter int PC_W = 21
)
(
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic            ce,
  input  wire logic            wb_cyc,
  input  wire logic            wb_stb,
  input  wire logic            wb_we,
  input  wire logic [4:0]      wb_adr,
  input  wire logic [3:0]      wb_sel,
  input  wire logic [31:0]     wb_wdata,
  output logic      [31:0]     wb_rdata_ff,
  output logic                 wb_ack_ff,
  input  wire logic [3:0]      ext_irq_pins,
  input  wire logic [3:0]      upper_port_pins,
  input  wire logic            core_sleep,
  input  wire logic            core_irq_ack,
  input  wire logic [PC_W-1:0] core_pc,
  input  wire logic [7:0]      core_work,
  input  wire logic [7:0]      core_status,
  input  wire logic [7:0]      core_bnk,
  output logic                 irq_high_ff,
  output logic                 irq_low_ff,
  output logic      [15:0]     irq_vector_ff,
  output logic                 wake_ff,
  output logic                 stack_push_ff,
  output logic      [PC_W-1:0] stack_pc_ff,
  output logic      [7:0]      shadow_work_ff,
  output logic      [7:0]      shadow_status_ff,
  output logic      [7:0]      shadow_bnk_ff
);

  ////////////////////////////////////////////////////////////////////////////
  logic        glb_ff;
  logic        giel_ff;
  logic        tmr_en_ff;
  logic        pc_en_ff;
  logic [3:0]  ext_en_ff;
  logic [3:0]  edge_sel_ff;
  logic [2:0]  ext_prio_ff;
  logic        tmr_prio_ff;
  logic        pc_prio_ff;
  logic        plen_ff;
  logic        tmr_run_ff;
  logic        tmr_mode16_ff;
  logic [15:0] tmr_cnt_ff;
  logic [3:0]  ext_flag_ff;
  logic        tmr_flag_ff;
  logic        pc_flag_ff;
  logic [3:0]  snap_ff;
  logic        snap_primed_ff;
  logic        sleep_prev_ff;
  logic [3:0]  sleep_en_ff;

  logic        wb_req;
  logic        wr_lo;
  logic        wr_hi;
  logic        hit_main;
  logic        hit_second;
  logic        hit_third;
  logic        hit_rstc;
  logic        hit_cfg;
  logic        hit_cnt;
  logic        hit_port;
  logic        hit_status;
  logic [7:0]  wd;
  logic [31:0] nxt_rdata;
  logic [3:0]  ext_pulse;
  logic [3:0]  ext_wr_en;
  logic [3:0]  ext_wr_val;
  logic        tmr_ovf;
  logic [15:0] nxt_tmr_cnt;
  logic        pc_mismatch;
  logic [5:0]  pend;
  logic [5:0]  hi_sel;
  logic        nxt_irq_high;
  logic        nxt_irq_low;
  logic        nxt_wake;
  logic        accept;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign wb_req     = wb_cyc & wb_stb & ~wb_ack_ff;
  assign wr_lo      = wb_req & wb_we & wb_sel[0];
  assign wr_hi      = wb_req & wb_we & wb_sel[1];
  assign wd         = wb_wdata[7:0];
  assign hit_main   = (wb_adr == etc_pkg::OFS_MAIN);
  assign hit_second = (wb_adr == etc_pkg::OFS_SECOND);
  assign hit_third  = (wb_adr == etc_pkg::OFS_THIRD);
  assign hit_rstc   = (wb_adr == etc_pkg::OFS_RSTC);
  assign hit_cfg    = (wb_adr == etc_pkg::OFS_TMR_CFG);
  assign hit_cnt    = (wb_adr == etc_pkg::OFS_TMR_CNT);
  assign hit_port   = (wb_adr == etc_pkg::OFS_PORT);
  assign hit_status = (wb_adr == etc_pkg::OFS_STATUS);

  always_comb
  begin
    nxt_rdata = '0;
    if (hit_main)
    begin
      nxt_rdata[etc_pkg::MAIN_GLB]       = glb_ff;
      nxt_rdata[etc_pkg::MAIN_GIEL]      = giel_ff;
      nxt_rdata[etc_pkg::MAIN_TMR_EN]    = tmr_en_ff;
      nxt_rdata[etc_pkg::MAIN_EXT0_EN]   = ext_en_ff[0];
      nxt_rdata[etc_pkg::MAIN_PC_EN]     = pc_en_ff;
      nxt_rdata[etc_pkg::MAIN_TMR_FLAG]  = tmr_flag_ff;
      nxt_rdata[etc_pkg::MAIN_EXT0_FLAG] = ext_flag_ff[0];
      nxt_rdata[etc_pkg::MAIN_PC_FLAG]   = pc_flag_ff;
    end
    else if (hit_second)
    begin
      nxt_rdata[etc_pkg::SEC_EDGE_LSB +: 4] = edge_sel_ff;
      nxt_rdata[etc_pkg::SEC_TMR_PRIO]      = tmr_prio_ff;
      nxt_rdata[etc_pkg::SEC_EXT3_PRIO]     = ext_prio_ff[2];
      nxt_rdata[etc_pkg::SEC_PC_PRIO]       = pc_prio_ff;
    end
    else if (hit_third)
    begin
      nxt_rdata[etc_pkg::THD_EXT2_PRIO]     = ext_prio_ff[1];
      nxt_rdata[etc_pkg::THD_EXT1_PRIO]     = ext_prio_ff[0];
      nxt_rdata[etc_pkg::THD_EN_LSB +: 3]   = ext_en_ff[3:1];
      nxt_rdata[etc_pkg::THD_FLAG_LSB +: 3] = ext_flag_ff[3:1];
    end
    else if (hit_rstc)
      nxt_rdata[etc_pkg::RSTC_PLEN] = plen_ff;
    else if (hit_cfg)
    begin
      nxt_rdata[etc_pkg::CFG_RUN]    = tmr_run_ff;
      nxt_rdata[etc_pkg::CFG_MODE16] = tmr_mode16_ff;
    end
    else if (hit_cnt)
      nxt_rdata[15:0] = tmr_cnt_ff;
    else if (hit_port)
      nxt_rdata[etc_pkg::PORT_LSB +: 4] = upper_port_pins;
    else if (hit_status)
      nxt_rdata[3:0] = {wake_ff, core_sleep, irq_low_ff, irq_high_ff};
  end

  // every access is answered one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_ack_ff   <= 1'b0;
      wb_rdata_ff <= '0;
    end
    else if (ce)
    begin
      wb_ack_ff   <= wb_req;
      wb_rdata_ff <= wb_req ? nxt_rdata : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      glb_ff        <= etc_pkg::MAIN_RST[etc_pkg::MAIN_GLB];
      giel_ff       <= etc_pkg::MAIN_RST[etc_pkg::MAIN_GIEL];
      tmr_en_ff     <= etc_pkg::MAIN_RST[etc_pkg::MAIN_TMR_EN];
      pc_en_ff      <= etc_pkg::MAIN_RST[etc_pkg::MAIN_PC_EN];
      ext_en_ff     <= {etc_pkg::THD_RST[etc_pkg::THD_EN_LSB +: 3],
                        etc_pkg::MAIN_RST[etc_pkg::MAIN_EXT0_EN]};
      edge_sel_ff   <= etc_pkg::SEC_RST[etc_pkg::SEC_EDGE_LSB +: 4];
      tmr_prio_ff   <= etc_pkg::SEC_RST[etc_pkg::SEC_TMR_PRIO];
      pc_prio_ff    <= etc_pkg::SEC_RST[etc_pkg::SEC_PC_PRIO];
      ext_prio_ff   <= {etc_pkg::SEC_RST[etc_pkg::SEC_EXT3_PRIO],
                        etc_pkg::THD_RST[etc_pkg::THD_EXT2_PRIO],
                        etc_pkg::THD_RST[etc_pkg::THD_EXT1_PRIO]};
      plen_ff       <= etc_pkg::RSTC_RST[etc_pkg::RSTC_PLEN];
      tmr_run_ff    <= etc_pkg::CFG_RST[etc_pkg::CFG_RUN];
      tmr_mode16_ff <= etc_pkg::CFG_RST[etc_pkg::CFG_MODE16];
    end
    else if (ce && wr_lo)
    begin
      if (hit_main)
      begin
        glb_ff       <= wd[etc_pkg::MAIN_GLB];
        giel_ff      <= wd[etc_pkg::MAIN_GIEL];
        tmr_en_ff    <= wd[etc_pkg::MAIN_TMR_EN]; // R11
        ext_en_ff[0] <= wd[etc_pkg::MAIN_EXT0_EN];
        pc_en_ff     <= wd[etc_pkg::MAIN_PC_EN];  // R14
      end
      else if (hit_second)
      begin
        edge_sel_ff    <= wd[etc_pkg::SEC_EDGE_LSB +: 4];
        tmr_prio_ff    <= wd[etc_pkg::SEC_TMR_PRIO];  // R12
        ext_prio_ff[2] <= wd[etc_pkg::SEC_EXT3_PRIO]; // R7
        pc_prio_ff     <= wd[etc_pkg::SEC_PC_PRIO];   // R15
      end
      else if (hit_third)
      begin
        ext_prio_ff[1:0] <= {wd[etc_pkg::THD_EXT2_PRIO], wd[etc_pkg::THD_EXT1_PRIO]}; // R7
        ext_en_ff[3:1]   <= wd[etc_pkg::THD_EN_LSB +: 3];
      end
      else if (hit_rstc)
        plen_ff <= wd[etc_pkg::RSTC_PLEN]; // R19
      else if (hit_cfg)
      begin
        tmr_run_ff    <= wd[etc_pkg::CFG_RUN];
        tmr_mode16_ff <= wd[etc_pkg::CFG_MODE16];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external edge inputs

  for (genvar i = 0; i < 4; i++)
  begin : g_edge
    etc_edge_detect u_edge
    (
      .clk           (clk),
      .nrst          (nrst),
      .ce            (ce),
      .pin           (ext_irq_pins[i]),
      .rising_sel    (edge_sel_ff[i]),
      .edge_pulse_ff (ext_pulse[i])
    );
  end

  always_comb
  begin
    ext_wr_en  = '0;
    ext_wr_val = '0;
    if (wr_lo && hit_main)
    begin
      ext_wr_en[0]  = 1'b1;
      ext_wr_val[0] = wd[etc_pkg::MAIN_EXT0_FLAG];
    end
    else if (wr_lo && hit_third)
    begin
      ext_wr_en[3:1]  = 3'h7;
      ext_wr_val[3:1] = wd[etc_pkg::THD_FLAG_LSB +: 3];
    end
  end

  // an edge in the cycle of a clearing write still sets the flag
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ext_flag_ff <= '0;
    else if (ce)
      ext_flag_ff <= ext_pulse | (ext_wr_en & ext_wr_val) | (~ext_wr_en & ext_flag_ff); // R2 R20
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer

  assign tmr_ovf = tmr_run_ff & (tmr_mode16_ff ? (tmr_cnt_ff == 16'hffff)         // R10
                                               : (tmr_cnt_ff[7:0] == 8'hff));     // R9

  always_comb
  begin
    nxt_tmr_cnt = tmr_cnt_ff;
    if (tmr_run_ff)
    begin
      if (tmr_mode16_ff)
        nxt_tmr_cnt = tmr_cnt_ff + 16'h0001;
      else
        nxt_tmr_cnt[7:0] = tmr_cnt_ff[7:0] + 8'h01;
    end
    if (wr_lo && hit_cnt)
      nxt_tmr_cnt[7:0] = wb_wdata[7:0];
    if (wr_hi && hit_cnt)
      nxt_tmr_cnt[15:8] = wb_wdata[15:8];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tmr_cnt_ff <= '0;
    else if (ce)
      tmr_cnt_ff <= nxt_tmr_cnt;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tmr_flag_ff <= 1'b0;
    else if (ce)
    begin
      if (tmr_ovf)
        tmr_flag_ff <= 1'b1; // R9 R10
      else if (wr_lo && hit_main)
        tmr_flag_ff <= wd[etc_pkg::MAIN_TMR_FLAG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port change

  assign pc_mismatch = snap_primed_ff & (upper_port_pins != snap_ff);

  // any access to the port register refreshes the reference level
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      snap_ff        <= '0;
      snap_primed_ff <= 1'b0;
    end
    else if (ce && (!snap_primed_ff || (wb_req && hit_port)))
    begin
      snap_ff        <= upper_port_pins;
      snap_primed_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pc_flag_ff <= 1'b0;
    else if (ce)
    begin
      if (pc_mismatch)
        pc_flag_ff <= 1'b1; // R13
      else if (wr_lo && hit_main)
        pc_flag_ff <= wd[etc_pkg::MAIN_PC_FLAG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority and request

  assign pend   = {tmr_flag_ff & tmr_en_ff, pc_flag_ff & pc_en_ff, ext_flag_ff & ext_en_ff}; // R3
  assign hi_sel = plen_ff ? {tmr_prio_ff, pc_prio_ff, ext_prio_ff, 1'b1} : 6'h3f; // R8 R19
  assign nxt_irq_high = glb_ff & (|(pend & hi_sel));                                // R6
  assign nxt_irq_low  = plen_ff & glb_ff & giel_ff & (|(pend & ~hi_sel));           // R19
  assign accept       = core_irq_ack & (irq_high_ff | irq_low_ff);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_high_ff   <= 1'b0;
      irq_low_ff    <= 1'b0;
      irq_vector_ff <= etc_pkg::VEC_HIGH;
    end
    else if (ce)
    begin
      irq_high_ff   <= nxt_irq_high;
      irq_low_ff    <= nxt_irq_low;
      irq_vector_ff <= nxt_irq_high ? etc_pkg::VEC_HIGH : etc_pkg::VEC_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep and wake

  assign nxt_wake = core_sleep & sleep_prev_ff &
                    ((|(ext_flag_ff & sleep_en_ff)) | (pc_flag_ff & pc_en_ff)); // R5

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sleep_prev_ff <= 1'b0;
      sleep_en_ff   <= '0;
      wake_ff       <= 1'b0;
    end
    else if (ce)
    begin
      sleep_prev_ff <= core_sleep;
      if (core_sleep && !sleep_prev_ff)
        sleep_en_ff <= ext_en_ff; // R5
      wake_ff <= nxt_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // context save

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stack_push_ff <= 1'b0;
      stack_pc_ff   <= '0;
    end
    else if (ce)
    begin
      stack_push_ff <= accept; // R16
      if (accept)
        stack_pc_ff <= core_pc; // R16
    end
  end

  etc_shadow_store #(.W(8)) u_shadow
  (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .capture   (accept),
    .work_in   (core_work),
    .status_in (core_status),
    .bnk_in    (core_bnk),
    .work_ff   (shadow_work_ff),
    .status_ff (shadow_status_ff),
    .bnk_ff    (shadow_bnk_ff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_accept;
    ce && core_irq_ack && (irq_high_ff || irq_low_ff);
  endsequence

  sequence s_saved;
    stack_push_ff && (stack_pc_ff == $past(core_pc)) && (shadow_work_ff == $past(core_work))
      && (shadow_status_ff == $past(core_status)) && (shadow_bnk_ff == $past(core_bnk));
  endsequence

  a_edge_sets_flag: assert property (ce && (ext_pulse != 4'h0) |=> // R2
    ((ext_flag_ff & $past(ext_pulse)) == $past(ext_pulse))) else $error("edge lost");
  a_flag_sticky: assert property (ce && !wr_lo |=> // R20
    ((ext_flag_ff & $past(ext_flag_ff)) == $past(ext_flag_ff))) else $error("flag fell");
  a_masked_quiet: assert property (ce && (pend == 6'h00) |=> !irq_high_ff && !irq_low_ff) // R3
    else $error("request without pending source");
  a_glb_gates: assert property (ce && !glb_ff |=> !irq_high_ff && !irq_low_ff) // R6
    else $error("request while globally disabled");
  a_no_low_level: assert property (!plen_ff ##1 !plen_ff |-> !irq_low_ff) // R19
    else $error("low request without priority levels");
  a_ext0_high: assert property (ce && glb_ff && ext_flag_ff[0] && ext_en_ff[0] |=> irq_high_ff) // R8
    else $error("source zero not high");
  a_tmr_wrap8: assert property (ce && tmr_run_ff && !tmr_mode16_ff && // R9
    (tmr_cnt_ff[7:0] == 8'hff) && !wr_lo |=> tmr_flag_ff && (tmr_cnt_ff[7:0] == 8'h00))
    else $error("8-bit wrap missed");
  a_tmr_wrap16: assert property (ce && tmr_run_ff && tmr_mode16_ff && (tmr_cnt_ff == 16'hffff) // R10
    |=> tmr_flag_ff) else $error("16-bit wrap missed");
  a_port_change: assert property (ce && pc_mismatch |=> pc_flag_ff) // R13
    else $error("port change missed");
  a_push_saves: assert property (s_accept |=> s_saved) // R16 R17
    else $error("context not saved");
  a_wake_sleep: assert property (ce && core_sleep && sleep_prev_ff && // R5
    ((ext_flag_ff & sleep_en_ff) != 4'h0) |=> wake_ff) else $error("no wake");
  a_ack_single: assert property (ce && wb_ack_ff |=> !wb_ack_ff) else $error("ack held");

endmodule

// File: etc_core_model.sv
`timescale 1ns/1ns
module etc_core_model
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ack_en,
  input  wire logic        sleep_req,
  input  wire logic        irq_high_ff,
  input  wire logic        irq_low_ff,
  output logic             core_sleep,
  output logic             core_irq_ack,
  output logic      [20:0] core_pc,
  output logic      [7:0]  core_work,
  output logic      [7:0]  core_status,
  output logic      [7:0]  core_bnk
);
  logic [23:0] save_ctx_ff;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      core_sleep   <= 1'b0;
      core_irq_ack <= 1'b0;
      core_pc      <= 21'h000000;
      core_work    <= 8'h00;
      core_status  <= 8'h00;
      core_bnk     <= 8'h00;
      save_ctx_ff  <= 24'h000000;
    end
    else
    begin
      core_sleep   <= sleep_req;
      // accept pulses, one idle cycle between
      core_irq_ack <= ack_en & (irq_high_ff | irq_low_ff) & !core_irq_ack;
      // context moves every cycle
      core_pc      <= core_pc + 21'h000123;
      core_work    <= core_work + 8'h11;
      core_status  <= ~core_status;
      core_bnk     <= core_bnk + 8'h05;
      if (core_irq_ack)
        save_ctx_ff <= {core_work, core_status, core_bnk};
    end
  end
endmodule

// File: ext_timer_change_irq_sources_tb.sv
`timescale 1ns/1ns
`define chk(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("Error %0t: got %h want %h", $time, (a), (e)); end end
module ext_timer_change_irq_sources_tb;
  logic        clk = 1'b0, nrst = 1'b0, ack_en = 1'b0, sleep_req = 1'b0, ce = 1'b1;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack_ff;
  logic [4:0]  wb_adr = 5'h00;
  logic [3:0]  wb_sel = 4'h0, ext_irq_pins = 4'h0, upper_port_pins = 4'h0;
  logic [31:0] wb_wdata = 32'h00000000, wb_rdata_ff;
  logic        core_sleep, core_irq_ack, irq_high_ff, irq_low_ff, wake_ff, stack_push_ff;
  logic [20:0] core_pc, stack_pc_ff, pc_q;
  logic [7:0]  core_work, core_status, core_bnk, shadow_work_ff, shadow_status_ff, shadow_bnk_ff;
  logic [15:0] irq_vector_ff;
  logic [23:0] ctx_q;
  logic        acc_q = 1'b0;
  int          err_total = 0, n_checks = 0, cyc_cnt = 0, n_acc = 0;
  logic [4:0]  rst_adr [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h1c, 5'h03};
  logic [7:0]  rst_val [7] = '{8'h00, 8'h7f, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00};
  // priority enable, second, third, main, expected high/low
  logic [26:0] pri_tbl [11] = '{
    {1'b1, 8'h7f, 8'h89, 8'hc0, 2'b01},
    {1'b1, 8'h7f, 8'hc9, 8'hc0, 2'b10},
    {1'b1, 8'h7f, 8'h52, 8'hc0, 2'b01},
    {1'b1, 8'h7d, 8'he4, 8'hc0, 2'b01},
    {1'b1, 8'h7b, 8'hc0, 8'he4, 2'b01},
    {1'b1, 8'h7f, 8'hc0, 8'he4, 2'b10},
    {1'b1, 8'h7e, 8'hc0, 8'hc9, 2'b01},
    {1'b1, 8'h7f, 8'hc0, 8'hc9, 2'b10},
    {1'b1, 8'h78, 8'h00, 8'hd2, 2'b10},
    {1'b0, 8'h7f, 8'h89, 8'hc0, 2'b10},
    {1'b1, 8'h7f, 8'h81, 8'hc0, 2'b00}};
  // timer config, start count, expected flag
  logic [18:0] tmr_tbl [4] = '{
    {2'b01, 16'h12fe, 1'b1},
    {2'b01, 16'h00f0, 1'b0},
    {2'b11, 16'h00fe, 1'b0},
    {2'b11, 16'hfffe, 1'b1}};
  etc_irq_sources dut_u (.clk(clk), .nrst(nrst), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata),
    .wb_rdata_ff(wb_rdata_ff), .wb_ack_ff(wb_ack_ff), .ext_irq_pins(ext_irq_pins),
    .upper_port_pins(upper_port_pins), .core_sleep(core_sleep), .core_irq_ack(core_irq_ack),
    .core_pc(core_pc), .core_work(core_work), .core_status(core_status), .core_bnk(core_bnk),
    .irq_high_ff(irq_high_ff), .irq_low_ff(irq_low_ff), .irq_vector_ff(irq_vector_ff),
    .wake_ff(wake_ff), .stack_push_ff(stack_push_ff), .stack_pc_ff(stack_pc_ff),
    .shadow_work_ff(shadow_work_ff), .shadow_status_ff(shadow_status_ff),
    .shadow_bnk_ff(shadow_bnk_ff));
  etc_core_model core_u (.clk(clk), .nrst(nrst), .ack_en(ack_en), .sleep_req(sleep_req),
    .irq_high_ff(irq_high_ff), .irq_low_ff(irq_low_ff), .core_sleep(core_sleep),
    .core_irq_ack(core_irq_ack), .core_pc(core_pc), .core_work(core_work),
    .core_status(core_status), .core_bnk(core_bnk));
  always #4 clk = ~clk;
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      err_total++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // context capture one cycle after each accept
  always @(negedge clk)
  begin
    if (acc_q)
    begin
      `chk(stack_push_ff, 1'b1)
      `chk(stack_pc_ff, pc_q)
      `chk({shadow_work_ff, shadow_status_ff, shadow_bnk_ff}, ctx_q)
    end
    else
      `chk(stack_push_ff, 1'b0)
    acc_q = core_irq_ack & (irq_high_ff | irq_low_ff) & nrst;
    pc_q = core_pc;
    ctx_q = {core_work, core_status, core_bnk};
    n_acc += acc_q;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic we, input logic [4:0] adr, input logic [15:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_sel   <= 4'h3;
    wb_wdata <= {16'h0000, wd};
    do @(posedge clk); while (wb_ack_ff !== 1'b1);
    rd = wb_rdata_ff;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] adr, input logic [15:0] wd);
    logic [31:0] rd;
    xfer(1'b1, adr, wd, rd);
  endtask
  task automatic rdc(input logic [4:0] adr, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] rd;
    xfer(1'b0, adr, 16'h0000, rd);
    `chk(rd & {24'h000000, m}, {24'h000000, e})
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    wt(12);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++)
      rdc(rst_adr[i], 8'hff, rst_val[i]);
    for (int p = 0; p < 2; p++)
    begin
      wr(etc_pkg::OFS_SECOND, {8'h00, 1'b0, {4{p[0]}}, 3'b111});
      ext_irq_pins <= {4{p[0]}};
      wt(4);
      wr(etc_pkg::OFS_MAIN, 16'h0000);
      wr(etc_pkg::OFS_THIRD, 16'h00c0);
      ext_irq_pins <= {4{~p[0]}};
      wt(4);
      rdc(etc_pkg::OFS_MAIN, 8'h02, 8'h00);
      rdc(etc_pkg::OFS_THIRD, 8'h07, 8'h00);
      ext_irq_pins <= {4{p[0]}};
      wt(4);
      rdc(etc_pkg::OFS_MAIN, 8'h02, 8'h02);
      rdc(etc_pkg::OFS_THIRD, 8'h07, 8'h07);
      wt(20);
      rdc(etc_pkg::OFS_THIRD, 8'h07, 8'h07);
    end
    for (int i = 0; i < 11; i++)
    begin
      wr(etc_pkg::OFS_RSTC, {8'h00, pri_tbl[i][26], 7'h00});
      wr(etc_pkg::OFS_SECOND, {8'h00, pri_tbl[i][25:18]});
      wr(etc_pkg::OFS_THIRD, {8'h00, pri_tbl[i][17:10]});
      wr(etc_pkg::OFS_MAIN, {8'h00, pri_tbl[i][9:2]});
      wt(3);
      @(negedge clk);
      `chk({irq_high_ff, irq_low_ff}, pri_tbl[i][1:0])
      `chk(irq_vector_ff, pri_tbl[i][1] ? etc_pkg::VEC_HIGH : etc_pkg::VEC_LOW)
      wr(etc_pkg::OFS_MAIN, 16'h0000);
      wr(etc_pkg::OFS_THIRD, 16'h00c0);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(etc_pkg::OFS_TMR_CFG, 16'h0000);
      wr(etc_pkg::OFS_TMR_CNT, tmr_tbl[i][16:1]);
      wr(etc_pkg::OFS_MAIN, 16'h0000);
      wr(etc_pkg::OFS_TMR_CFG, {14'h0000, tmr_tbl[i][18:17]});
      // frozen count cannot reach the wrap
      ce <= (i != 1);
      wt(24);
      ce <= 1'b1;
      rdc(etc_pkg::OFS_MAIN, 8'h04, {5'h00, tmr_tbl[i][0], 2'b00});
    end
    wr(etc_pkg::OFS_TMR_CFG, 16'h0000);
    rdc(etc_pkg::OFS_PORT, 8'hf0, 8'h00);
    wr(etc_pkg::OFS_MAIN, 16'h0000);
    upper_port_pins <= 4'h5;
    wt(4);
    rdc(etc_pkg::OFS_MAIN, 8'h01, 8'h01);
    rdc(etc_pkg::OFS_PORT, 8'hf0, 8'h50);
    wr(etc_pkg::OFS_MAIN, 16'h0000);
    rdc(etc_pkg::OFS_MAIN, 8'h01, 8'h00);
    wr(etc_pkg::OFS_MAIN, 16'h0092);
    ack_en <= 1'b1;
    wt(12);
    ack_en <= 1'b0;
    wt(2);
    `chk(n_acc > 3, 1'b1)
    ext_irq_pins <= 4'h0;
    wt(4);
    wr(etc_pkg::OFS_MAIN, 16'h0000);
    wr(etc_pkg::OFS_THIRD, 16'h00c0);
    wr(etc_pkg::OFS_SECOND, 16'h007f);
    wr(etc_pkg::OFS_MAIN, 16'h0010);
    sleep_req <= 1'b1;
    wt(3);
    wr(etc_pkg::OFS_THIRD, 16'h00c8);
    ext_irq_pins <= 4'h2;
    wt(4);
    @(negedge clk);
    `chk(wake_ff, 1'b0)
    @(posedge clk);
    ext_irq_pins <= 4'h3;
    wt(4);
    @(negedge clk);
    `chk(wake_ff, 1'b1)
    `chk(irq_high_ff, 1'b0)
    rdc(etc_pkg::OFS_STATUS, 8'h0f, 8'h0c);
    sleep_req <= 1'b0;
    wr(etc_pkg::OFS_MAIN, 16'h0092);
    wt(3);
    @(negedge clk);
    `chk(irq_high_ff, 1'b1)
    `chk(irq_vector_ff, etc_pkg::VEC_HIGH)
    complete_run();
  end
endmodule
